// File: logic/uemr_modem_data.sv
// Emulated UART modem control/status, divisor latches and holding registers
`timescale 1ns/10ps

// =====================================
// Receive character buffer
module uemr_fifo #(
   parameter int W = 10,
   parameter int D = 32
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   input wire logic i_out_ready,
   output logic o_out_valid,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wptr_q, rptr_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic in_ready_q;
   wire push = i_in_valid && in_ready_q;
   wire pop = o_out_valid && i_out_ready;
   assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   assign o_in_ready = in_ready_q;
   assign o_out_valid = cnt_q != '0;
   assign o_out_data = mem[rptr_q];
   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[wptr_q] <= i_in_data;
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         in_ready_q <= 1'b0;
      end else begin
         wptr_q <= wptr_q + AW'(push);
         rptr_q <= rptr_q + AW'(pop);
         cnt_q <= cnt_d;
         in_ready_q <= cnt_d != (AW+1)'(D);
      end
   end
endmodule

// =====================================
// Top: PC-facing registers and core/engine side
module uemr_modem_data
   import uemr_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_pc_addr,
   input wire logic i_pc_wr,
   input wire logic i_pc_rd,
   input wire logic [7:0] i_pc_wdata,
   input wire logic i_dlab,
   input wire logic i_msi_enable,
   input wire logic i_rda_enable,
   input wire logic i_lsr_read,
   output logic [7:0] o_pc_rdata,
   output logic o_msi_irq,
   output logic o_rda_irq,
   input wire logic i_core_msr_wr,
   input wire logic [3:0] i_core_modem,
   input wire uemr_evt_t i_evt_enable,
   output uemr_evt_t o_evt,
   output logic [3:0] o_ctrl_status,
   output logic o_loop,
   output logic [15:0] o_divisor,
   input wire logic i_rx_valid,
   input wire uemr_rx_char_t i_rx_char,
   output logic o_rx_ready,
   input wire logic i_baud_tick,
   input wire logic [3:0] i_rx_div,
   input wire logic i_rx_slow_en,
   input wire logic [3:0] i_tx_div,
   input wire logic i_tx_slow_en,
   output logic o_data_ready,
   output logic o_lsr_fe,
   output logic o_lsr_pe,
   output logic o_thre,
   output logic o_tx_req,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ack
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   // =====================================
   // Register state
   logic [4:0] mcr_q;
   logic [3:0] core_msr_q, stat_prev_q, delta_q;
   logic [15:0] div_q;
   logic [7:0] rbr_q, thr_q, rdata_q;
   logic dr_q, fe_q, pe_q, thre_q, tx_pend_q, tx_req_q;
   logic msi_q, rda_q;
   logic [3:0] rx_cnt_q, tx_cnt_q;
   uemr_evt_t evt_q;
   logic rx_valid;
   uemr_rx_char_t rx_head;

   // =====================================
   // Decode
   wire hit_data = i_pc_addr == UEMR_OFF_DATA;
   wire wr_thr = i_pc_wr && hit_data && !i_dlab;
   wire wr_dll = i_pc_wr && hit_data && i_dlab;
   wire wr_dlm = i_pc_wr && i_pc_addr == UEMR_OFF_DLM && i_dlab;
   wire wr_mcr = i_pc_wr && i_pc_addr == UEMR_OFF_MCR;
   wire rd_rbr = i_pc_rd && hit_data && !i_dlab;
   wire rd_msr = i_pc_rd && i_pc_addr == UEMR_OFF_MSR;

   // =====================================
   // Modem status lines and change flags
   // Loop wiring: CTS<-RTS, DSR<-DTR, RI<-Out1, DCD<-Out2
   wire [3:0] loop_stat = {mcr_q[UEMR_MCR_OUT2], mcr_q[UEMR_MCR_OUT1],
                           mcr_q[UEMR_MCR_DTR], mcr_q[UEMR_MCR_RTS]};
   wire [3:0] stat = mcr_q[UEMR_MCR_LOOP] ? loop_stat : core_msr_q;
   wire [3:0] chg = stat ^ stat_prev_q;
   wire [3:0] delta_set = {chg[UEMR_ST_DCD],
                           stat_prev_q[UEMR_ST_RI] & ~stat[UEMR_ST_RI],
                           chg[UEMR_ST_DSR],
                           chg[UEMR_ST_CTS]};
   // New change in the read cycle survives the clear
   wire [3:0] delta_d = (rd_msr ? 4'h0 : delta_q) | delta_set;
   wire mcr_changed = i_pc_wdata[3:0] != mcr_q[3:0];

   // =====================================
   // Events to the core
   uemr_evt_t evt_d;
   assign evt_d.modem_control_reg = wr_mcr && mcr_changed && i_evt_enable.modem_control_reg;
   assign evt_d.loop = wr_mcr && i_pc_wdata[UEMR_MCR_LOOP] && !mcr_q[UEMR_MCR_LOOP]
                       && i_evt_enable.loop;
   assign evt_d.dll = wr_dll && i_evt_enable.dll;
   assign evt_d.divisor_high_byte = wr_dlm && i_evt_enable.divisor_high_byte;

   // =====================================
   // Receive path: engine -> buffer -> holding register
   wire rx_gate = !i_rx_slow_en || rx_cnt_q == UEMR_CNT_RST;
   wire rx_pop = rx_valid && !dr_q && rx_gate;
   uemr_fifo #(.W(UEMR_RX_WIDTH), .D(UEMR_RX_DEPTH)) u_rx_fifo (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_in_valid(i_rx_valid),
      .i_in_data(i_rx_char),
      .o_in_ready(o_rx_ready),
      .i_out_ready(rx_pop),
      .o_out_valid(rx_valid),
      .o_out_data(rx_head)
   );

   // =====================================
   // Transmit path: PC write -> paced request -> engine read
   wire tx_gate = !i_tx_slow_en || tx_cnt_q == UEMR_CNT_RST;
   wire tx_take = tx_req_q && i_tx_ack;

   // =====================================
   // Read mux
   wire [7:0] rd_lo = i_dlab ? div_q[7:0] : rbr_q;
   wire [7:0] rd_hi = i_dlab ? div_q[15:8] : UEMR_BYTE_RST;
   wire [7:0] rd_mux = hit_data ? rd_lo :
                       i_pc_addr == UEMR_OFF_DLM ? rd_hi :
                       i_pc_addr == UEMR_OFF_MCR ? {3'b000, mcr_q} :
                       i_pc_addr == UEMR_OFF_MSR ? {stat, delta_q} : UEMR_BYTE_RST;

   // =====================================
   // Control and modem state
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         mcr_q <= UEMR_MCR_RST;
         core_msr_q <= UEMR_MSR_RST;
         stat_prev_q <= UEMR_MSR_RST;
         delta_q <= UEMR_MSR_RST;
         msi_q <= 1'b0;
         evt_q <= '0;
         rdata_q <= UEMR_BYTE_RST;
      end else begin
         if (wr_mcr) begin
            mcr_q <= i_pc_wdata[4:0];
         end
         if (i_core_msr_wr) begin
            core_msr_q <= i_core_modem;
         end
         stat_prev_q <= stat;
         delta_q <= delta_d;
         msi_q <= (|delta_q) && i_msi_enable;
         evt_q <= evt_d;
         if (i_pc_rd) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // =====================================
   // Divisor latches
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         div_q <= UEMR_DIV_RST;
      end else begin
         if (wr_dll) begin
            div_q[7:0] <= i_pc_wdata;
         end
         if (wr_dlm) begin
            div_q[15:8] <= i_pc_wdata;
         end
      end
   end

   // =====================================
   // Receive holding and line flags
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rbr_q <= UEMR_BYTE_RST;
         dr_q <= 1'b0;
         fe_q <= 1'b0;
         pe_q <= 1'b0;
         rda_q <= 1'b0;
         rx_cnt_q <= UEMR_CNT_RST;
      end else begin
         if (rx_pop) begin
            rbr_q <= rx_head.data;
            rx_cnt_q <= i_rx_div;
         end else if (i_baud_tick && rx_cnt_q != UEMR_CNT_RST) begin
            rx_cnt_q <= rx_cnt_q - 4'h1;
         end
         dr_q <= rx_pop || (dr_q && !rd_rbr);
         fe_q <= (rx_pop && rx_head.fe) || (fe_q && !i_lsr_read);
         pe_q <= (rx_pop && rx_head.pe) || (pe_q && !i_lsr_read);
         rda_q <= dr_q && i_rda_enable;
      end
   end

   // =====================================
   // Transmit holding and request
   // A new PC write in the ack cycle wins: the byte is fresh
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         thr_q <= UEMR_BYTE_RST;
         thre_q <= 1'b1;
         tx_pend_q <= 1'b0;
         tx_req_q <= 1'b0;
         tx_cnt_q <= UEMR_CNT_RST;
      end else begin
         if (wr_thr) begin
            thr_q <= i_pc_wdata;
            thre_q <= 1'b0;
            tx_pend_q <= 1'b1;
            tx_req_q <= 1'b0;
            tx_cnt_q <= i_tx_div;
         end else begin
            if (tx_take) begin
               thre_q <= 1'b1;
               tx_pend_q <= 1'b0;
               tx_req_q <= 1'b0;
            end else if (tx_pend_q && tx_gate) begin
               tx_req_q <= 1'b1;
            end
            if (i_baud_tick && tx_pend_q && tx_cnt_q != UEMR_CNT_RST) begin
               tx_cnt_q <= tx_cnt_q - 4'h1;
            end
         end
      end
   end

   // =====================================
   // Outputs
   assign o_pc_rdata = rdata_q;
   assign o_msi_irq = msi_q;
   assign o_rda_irq = rda_q;
   assign o_evt = evt_q;
   assign o_ctrl_status = mcr_q[3:0];
   assign o_loop = mcr_q[UEMR_MCR_LOOP];
   assign o_divisor = div_q;
   assign o_data_ready = dr_q;
   assign o_lsr_fe = fe_q;
   assign o_lsr_pe = pe_q;
   assign o_thre = thre_q;
   assign o_tx_req = tx_req_q;
   assign o_tx_data = thr_q;

   // =====================================
   // Checks
   dtr_rts_set_a: assert property (
      wr_mcr |=> o_ctrl_status[1:0] == $past(i_pc_wdata[1:0]))
      else $error("DTR/RTS status not forced by write");
   out_bits_set_a: assert property (
      wr_mcr |=> o_ctrl_status[3:2] == $past(i_pc_wdata[3:2]))
      else $error("Out1/Out2 status not forced by write");
   loop_route_a: assert property (
      wr_mcr && i_pc_wdata[UEMR_MCR_LOOP] |=> stat[UEMR_ST_CTS] == $past(i_pc_wdata[1])
      && stat[UEMR_ST_DCD] == $past(i_pc_wdata[3]))
      else $error("Loopback routing wrong");
   loop_event_a: assert property (
      wr_mcr && i_pc_wdata[UEMR_MCR_LOOP] && !o_loop && i_evt_enable.loop |=> o_evt.loop)
      else $error("Loop entry event missing");
   cts_delta_a: assert property (
      $changed(stat[UEMR_ST_CTS]) |=> delta_q[UEMR_ST_CTS])
      else $error("CTS change flag not set");
   dsr_delta_a: assert property (
      $changed(stat[UEMR_ST_DSR]) |=> delta_q[UEMR_ST_DSR])
      else $error("DSR change flag not set");
   ring_edge_a: assert property (
      $rose(delta_q[UEMR_ST_RI]) |-> $past(stat[UEMR_ST_RI], 2) && !$past(stat[UEMR_ST_RI]))
      else $error("Ring flag set without falling edge");
   dcd_delta_a: assert property (
      $changed(stat[UEMR_ST_DCD]) |=> delta_q[UEMR_ST_DCD])
      else $error("DCD change flag not set");
   msr_clear_a: assert property (
      rd_msr && chg == 4'h0 |=> delta_q == 4'h0)
      else $error("Change flags not cleared by read");
   msi_raise_a: assert property (
      (|delta_q) && i_msi_enable |=> o_msi_irq)
      else $error("Modem interrupt missing");
   msi_mask_a: assert property (
      !i_msi_enable |=> !o_msi_irq)
      else $error("Modem interrupt not masked");
   core_bits_a: assert property (
      i_core_msr_wr && !o_loop && !wr_mcr |=> stat == $past(i_core_modem))
      else $error("Core status bits not shown");
   div_low_a: assert property (
      wr_dll |=> o_divisor[7:0] == $past(i_pc_wdata) && o_evt.dll == $past(i_evt_enable.dll))
      else $error("Low divisor write lost");
   div_high_a: assert property (
      wr_dlm |=> o_divisor[15:8] == $past(i_pc_wdata) && o_evt.divisor_high_byte == $past(i_evt_enable.divisor_high_byte))
      else $error("High divisor write lost");
   mcr_event_a: assert property (
      wr_mcr && i_pc_wdata[3:0] == o_ctrl_status |=> !o_evt.modem_control_reg)
      else $error("Control event without change");
   rx_pace_a: assert property (
      rx_pop && i_rx_slow_en |=> !rx_pop [*1] ##0 (rx_cnt_q == $past(i_rx_div)))
      else $error("Receive divider not loaded");
   thr_request_a: assert property (
      wr_thr |=> !o_thre && !o_tx_req && o_tx_data == $past(i_pc_wdata))
      else $error("Transmit write not posted");
   thre_set_a: assert property (
      tx_take && !wr_thr |=> o_thre && !o_tx_req)
      else $error("Holding empty not set on engine read");
endmodule

// File: logic/uemr_pkg.sv
// Shared constants and types for the emulated modem/data register block
package uemr_pkg;
   // =====================================
   // PC register offsets (divisor latches share 0/1 with DLAB set)
   localparam logic [2:0] UEMR_OFF_DATA = 3'h0;
   localparam logic [2:0] UEMR_OFF_DLM = 3'h1;
   localparam logic [2:0] UEMR_OFF_MCR = 3'h4;
   localparam logic [2:0] UEMR_OFF_MSR = 3'h6;
   // =====================================
   // Modem control fields
   localparam int UEMR_MCR_DTR = 0;
   localparam int UEMR_MCR_RTS = 1;
   localparam int UEMR_MCR_OUT1 = 2;
   localparam int UEMR_MCR_OUT2 = 3;
   localparam int UEMR_MCR_LOOP = 4;
   // Modem status: deltas in [3:0], status lines in [7:4]
   localparam int UEMR_ST_CTS = 0;
   localparam int UEMR_ST_DSR = 1;
   localparam int UEMR_ST_RI = 2;
   localparam int UEMR_ST_DCD = 3;
   // =====================================
   // Reset values
   localparam logic [4:0] UEMR_MCR_RST = 5'h00;
   localparam logic [3:0] UEMR_MSR_RST = 4'h0;
   localparam logic [15:0] UEMR_DIV_RST = 16'h0000;
   localparam logic [7:0] UEMR_BYTE_RST = 8'h00;
   localparam logic [3:0] UEMR_CNT_RST = 4'h0;
   // =====================================
   // Receive buffer shape
   localparam int UEMR_RX_DEPTH = 32;
   localparam int UEMR_RX_WIDTH = 10;
   // =====================================
   // Types
   typedef struct packed {
      logic fe;
      logic pe;
      logic [7:0] data;
   } uemr_rx_char_t;
   typedef struct packed {
      logic loop;
      logic divisor_high_byte;
      logic dll;
      logic modem_control_reg;
   } uemr_evt_t;
endpackage

// File: testbench/uemr_pc_host.sv
// PC host model issuing I/O register accesses to the emulated serial port
`timescale 1ns/10ps
module uemr_pc_host (
   input wire logic i_ref_clk,
   input wire logic [7:0] i_rdata,
   output logic [2:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_wdata
);
   initial begin
      o_addr = 3'h7;
      o_wr = 1'h0;
      o_rd = 1'h0;
      o_wdata = 8'h00;
   end
   // ====================
   // One-cycle strobes, launched at falling edges
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'h1;
      @(negedge i_ref_clk);
      o_wr = 1'h0;
      // Released bus must not keep the old byte
      o_wdata = ~d;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(negedge i_ref_clk);
      o_addr = a;
      o_rd = 1'h1;
      @(negedge i_ref_clk);
      o_rd = 1'h0;
      d = i_rdata;
   endtask
endmodule

// File: testbench/uemr_modem_data_bench.sv
// Self-checking bench for the emulated modem/data register block
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module uemr_modem_data_bench;
   import uemr_pkg::*;
   typedef struct packed {
      logic dlab;
      logic [2:0] a;
      logic [7:0] d;
      logic [7:0] exp;
      logic [3:0] ev;
   } uemr_row_t;
   localparam uemr_row_t ROWS [8] = '{24'h40_F0F1, 24'h4E_F0F0, 24'h85_A5A2, 24'h9A_5A54,
      24'h6F_F000, 24'h23_3000, 24'h17_7000, 24'h40_0001};
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic dlab = 1'h0, msi_en = 1'h0, rda_en = 1'h0, lsr_rd = 1'h0, core_wr = 1'h0;
   logic rx_valid = 1'h0, tick = 1'h0, rx_slow = 1'h0, tx_slow = 1'h0, tx_ack = 1'h0;
   logic [3:0] core_modem = 4'h0, rx_div = 4'h0, tx_div = 4'h0;
   uemr_evt_t evt_en = 4'hF;
   uemr_rx_char_t rx_char = 10'h000;
   uemr_evt_t evt;
   logic [2:0] addr;
   logic wr, rd, msi_irq, rda_irq, rx_ready, data_ready, fe, pe, thre, tx_req, loop_o, ok;
   logic [7:0] wdata, rdata, rd_val, tx_data;
   logic [3:0] ctrl;
   logic [15:0] divisor;
   int err_total = 0, checked = 0, n;

   uemr_pc_host uemr_pc_host_inst (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr),
      .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
   uemr_modem_data uemr_modem_data_inst (.i_ref_clk(clk), .i_rst(rst), .i_pc_addr(addr),
      .i_pc_wr(wr), .i_pc_rd(rd), .i_pc_wdata(wdata), .i_dlab(dlab), .i_msi_enable(msi_en),
      .i_rda_enable(rda_en), .i_lsr_read(lsr_rd), .o_pc_rdata(rdata), .o_msi_irq(msi_irq),
      .o_rda_irq(rda_irq), .i_core_msr_wr(core_wr), .i_core_modem(core_modem),
      .i_evt_enable(evt_en), .o_evt(evt), .o_ctrl_status(ctrl), .o_loop(loop_o),
      .o_divisor(divisor), .i_rx_valid(rx_valid), .i_rx_char(rx_char), .o_rx_ready(rx_ready),
      .i_baud_tick(tick), .i_rx_div(rx_div), .i_rx_slow_en(rx_slow), .i_tx_div(tx_div),
      .i_tx_slow_en(tx_slow), .o_data_ready(data_ready), .o_lsr_fe(fe), .o_lsr_pe(pe),
      .o_thre(thre), .o_tx_req(tx_req), .o_tx_data(tx_data), .i_tx_ack(tx_ack));

   initial forever #5 clk = ~clk;
   // ====================
   // Helpers
   task automatic finish_test;
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic push(input logic [9:0] c, output logic acc);
      @(negedge clk);
      rx_valid = 1'h1;
      rx_char = c;
      for (int k = 0; k < 4; k++) if (rx_ready !== 1'h1) @(negedge clk);
      acc = (rx_ready === 1'h1);
      @(negedge clk);
      rx_valid = 1'h0;
      rx_char = ~c;
   endtask
   task automatic pulse_ticks(input int cnt);
      repeat (cnt) begin
         @(negedge clk);
         tick = 1'h1;
         @(negedge clk);
         tick = 1'h0;
      end
   endtask
   task automatic wait_sig(ref logic s);
      for (int k = 0; k < 40 && s !== 1'h1; k++) @(negedge clk);
   endtask
   task automatic ack;
      @(negedge clk);
      tx_ack = 1'h1;
      @(negedge clk);
      tx_ack = 1'h0;
      `CHK({thre, tx_req}, 2'h2)
   endtask
   initial begin
      #200us;
      err_total++;
      finish_test();
   end
   // ====================
   // Main sequence
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'h0;
      `CHK({thre, tx_req, msi_irq, loop_o, ctrl, divisor}, 24'h80_0000)
      foreach (ROWS[i]) begin
         dlab = ROWS[i].dlab;
         uemr_pc_host_inst.wr_reg(ROWS[i].a, ROWS[i].d);
         `CHK(evt, ROWS[i].ev)
         uemr_pc_host_inst.rd_reg(ROWS[i].a, rd_val);
         `CHK(rd_val, ROWS[i].exp)
      end
      `CHK(divisor, 16'hA55A)
      evt_en = 4'h0;
      dlab = 1'h1;
      uemr_pc_host_inst.wr_reg(UEMR_OFF_DATA, 8'h77);
      `CHK({evt, divisor}, 20'h0_A577)
      evt_en = 4'hF;
      dlab = 1'h0;
      // Loopback with slowdown on, as users are told to do
      msi_en = 1'h1;
      rx_slow = 1'h1;
      uemr_pc_host_inst.wr_reg(UEMR_OFF_MCR, 8'h11);
      `CHK({evt, loop_o, ctrl}, 9'h131)
      repeat (2) @(negedge clk);
      `CHK(msi_irq, 1'h1)
      uemr_pc_host_inst.rd_reg(UEMR_OFF_MSR, rd_val);
      `CHK(rd_val, 8'h22)
      uemr_pc_host_inst.rd_reg(UEMR_OFF_MSR, rd_val);
      `CHK({rd_val, msi_irq}, 9'h040)
      msi_en = 1'h0;
      uemr_pc_host_inst.wr_reg(UEMR_OFF_MCR, 8'h1F);
      `CHK({evt, ctrl}, 8'h1F)
      repeat (2) @(negedge clk);
      `CHK(msi_irq, 1'h0)
      uemr_pc_host_inst.rd_reg(UEMR_OFF_MSR, rd_val);
      `CHK(rd_val, 8'hF9)
      uemr_pc_host_inst.wr_reg(UEMR_OFF_MCR, 8'h10);
      uemr_pc_host_inst.rd_reg(UEMR_OFF_MSR, rd_val);
      `CHK(rd_val, 8'h0F)
      uemr_pc_host_inst.wr_reg(UEMR_OFF_MCR, 8'h10);
      `CHK(evt, 4'h0)
      uemr_pc_host_inst.wr_reg(UEMR_OFF_MCR, 8'h00);
      `CHK({evt, loop_o}, 5'h00)
      @(negedge clk);
      core_modem = 4'h5;
      core_wr = 1'h1;
      @(negedge clk);
      core_wr = 1'h0;
      repeat (2) @(negedge clk);
      uemr_pc_host_inst.rd_reg(UEMR_OFF_MSR, rd_val);
      `CHK(rd_val, 8'h51)
      // Receive path: one flagged character
      rda_en = 1'h1;
      push(10'h3C3, ok);
      wait_sig(data_ready);
      `CHK({data_ready, fe, pe}, 3'h7)
      @(negedge clk);
      `CHK(rda_irq, 1'h1)
      uemr_pc_host_inst.rd_reg(UEMR_OFF_DATA, rd_val);
      `CHK({rd_val, data_ready}, 9'h186)
      @(negedge clk);
      lsr_rd = 1'h1;
      @(negedge clk);
      lsr_rd = 1'h0;
      `CHK({fe, pe}, 2'h0)
      // Fill with the reader stalled, pacing holds back delivery
      rx_div = 4'h2;
      n = 0;
      do begin
         push(10'(n), ok);
         if (ok) n++;
      end while (ok && n < 40);
      `CHK({n[7:0], rx_ready}, 9'h042)
      uemr_pc_host_inst.rd_reg(UEMR_OFF_DATA, rd_val);
      `CHK(rd_val, 8'h00)
      repeat (6) @(negedge clk);
      `CHK(data_ready, 1'h0)
      pulse_ticks(2);
      wait_sig(data_ready);
      `CHK(data_ready, 1'h1)
      rx_slow = 1'h0;
      for (int i = 1; i < 33; i++) begin
         wait_sig(data_ready);
         uemr_pc_host_inst.rd_reg(UEMR_OFF_DATA, rd_val);
         `CHK(rd_val, 8'(i))
      end
      repeat (4) @(negedge clk);
      `CHK({data_ready, rx_ready}, 2'h1)
      // Transmit path, immediate then paced
      uemr_pc_host_inst.wr_reg(UEMR_OFF_DATA, 8'h3C);
      `CHK({thre, tx_req, tx_data}, 10'h03C)
      @(negedge clk);
      `CHK(tx_req, 1'h1)
      ack();
      tx_slow = 1'h1;
      tx_div = 4'h3;
      uemr_pc_host_inst.wr_reg(UEMR_OFF_DATA, 8'hA5);
      repeat (4) @(negedge clk);
      `CHK({thre, tx_req, tx_data}, 10'h0A5)
      pulse_ticks(3);
      wait_sig(tx_req);
      `CHK(tx_req, 1'h1)
      ack();
      finish_test();
   end
endmodule
